/* File: hw/pcscr_regs.sv */
// Purpose: config registers and sync-gated active copies for peak cancel stages 2..4
// Assumes: register master per plain strobe port, sync pins asynchronous to clock
// Notes:   delay and count outputs get active copies only; detect and gain writes reach the peak cut path directly
`timescale 1ns/1ps
module pcscr_regs (
    input  wire logic                                           clock,
    input  wire logic                                           rst_n,
    input  wire logic [pcscr_pkg::PCSCR_ADDR_W-1:0]             reg_addr,
    input  wire logic [pcscr_pkg::PCSCR_DATA_W-1:0]             reg_wdata,
    input  wire logic                                           reg_write,
    input  wire logic                                           reg_read,
    output logic      [pcscr_pkg::PCSCR_DATA_W-1:0]             reg_rdata,
    input  wire logic                                           timer_pin,
    input  wire logic                                           sync_a_pin,
    input  wire logic                                           sync_b_pin,
    input  pcscr_pkg::pcscr_peak_t                              peak_in [pcscr_pkg::PCSCR_STAGES],
    input  wire logic [pcscr_pkg::PCSCR_STAGES-1:0]             canceller_free,
    output pcscr_pkg::pcscr_cancel_t                            cancel_out [pcscr_pkg::PCSCR_STAGES],
    output logic      [pcscr_pkg::PCSCR_DELAY_W-1:0]            active_delay [pcscr_pkg::PCSCR_STAGES],
    output logic      [pcscr_pkg::PCSCR_COUNT_W-1:0]            active_count [pcscr_pkg::PCSCR_COUNTS]
);
    import pcscr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // storage

    logic [15:0] stage_detect [PCSCR_STAGES];
    logic [15:0] stage_gain   [PCSCR_STAGES];
    logic [7:0]  stage_delay  [PCSCR_STAGES];
    logic [3:0]  stage_count  [PCSCR_COUNTS];
    logic [2:0]  cancel_sel;
    logic [2:0]  resource_sel;
    logic [15:0] stage_rd     [PCSCR_STAGES];
    logic [15:0] count_rd     [PCSCR_COUNTS];
    logic [15:0] next_rdata;
    logic        cancel_event;
    logic        resource_event;

    ////////////////////////////////////////////////////////////////////////////////
    // sync pin inputs: two flops, then an edge flop that reads only the second

    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_prev;
    logic [2:0] pin_rise;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            pin_prev <= 3'h0;
        end else begin
            pin_meta <= {sync_b_pin, sync_a_pin, timer_pin};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // a held pin counts once, on its rising edge
    assign pin_rise = pin_sync & ~pin_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // own control registers: selectors and software trigger

    logic wr_cancel_sel;
    logic wr_resource_sel;
    logic wr_software_sync_source;
    logic sw_cancel;
    logic sw_resource;

    assign wr_cancel_sel   = reg_write && reg_addr == PCSCR_OFS_CANCEL_SEL;
    assign wr_resource_sel = reg_write && reg_addr == PCSCR_OFS_RESOURCE_SEL;
    assign wr_software_sync_source   = reg_write && reg_addr == PCSCR_OFS_SOFTWARE_SYNC_SOURCE;
    assign sw_cancel       = wr_software_sync_source && reg_wdata[PCSCR_SW_CANCEL_BIT];
    assign sw_resource     = wr_software_sync_source && reg_wdata[PCSCR_SW_RESOURCE_BIT];

    // selector codes stored raw, so invalid codes read back as written
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cancel_sel   <= PCSCR_RST_SEL;
            resource_sel <= PCSCR_RST_SEL;
        end else begin
            if (wr_cancel_sel) begin
                cancel_sel <= reg_wdata[2:0];
            end
            if (wr_resource_sel) begin
                resource_sel <= reg_wdata[2:0];
            end
        end
    end

    // one selector per sync domain; software trigger bit picks which one fires
    pcscr_sync_sel u_cancel_sync (
        .clock        (clock),
        .rst_n        (rst_n),
        .select       (cancel_sel),
        .sw_event     (sw_cancel),
        .timer_event  (pin_rise[0]),
        .sync_a_event (pin_rise[1]),
        .sync_b_event (pin_rise[2]),
        .event_pulse  (cancel_event)
    );

    pcscr_sync_sel u_resource_sync (
        .clock        (clock),
        .rst_n        (rst_n),
        .select       (resource_sel),
        .sw_event     (sw_resource),
        .timer_event  (pin_rise[0]),
        .sync_a_event (pin_rise[1]),
        .sync_b_event (pin_rise[2]),
        .event_pulse  (resource_event)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // per-stage thresholds, delay and peak decision

    for (genvar s = 0; s < PCSCR_STAGES; s++) begin : g_stage
        logic wr_det;
        logic wr_gain;
        logic wr_dly;
        logic avail;
        logic over;

        assign wr_det  = reg_write && reg_addr == PCSCR_OFS_DETECT[s];
        assign wr_gain = reg_write && reg_addr == PCSCR_OFS_GAIN[s];
        assign wr_dly  = reg_write && reg_addr == PCSCR_OFS_DELAY[s];

        // reserved delay bits read as zero
        assign stage_rd[s] = ({16{reg_addr == PCSCR_OFS_DETECT[s]}} & stage_detect[s])
                           | ({16{reg_addr == PCSCR_OFS_GAIN[s]}} & stage_gain[s])
                           | ({16{reg_addr == PCSCR_OFS_DELAY[s]}} & {8'h00, stage_delay[s]});

        // stage 2 count lives elsewhere; stages 3, 4 also need an active allocation
        if (s == 0) begin : g_avail_ext
            assign avail = canceller_free[s];
        end else begin : g_avail_cnt
            assign avail = canceller_free[s] && (active_count[s-1] != 4'h0);
        end

        // strictly above the detect level triggers a cut
        assign over = peak_in[s].valid && (peak_in[s].mag_sq > stage_detect[s]);

        // full-width thresholds, low-byte delay, all clear to zero
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                stage_detect[s] <= PCSCR_RST_THRESH;
                stage_gain[s]   <= PCSCR_RST_THRESH;
                stage_delay[s]  <= PCSCR_RST_DELAY;
            end else begin
                if (wr_det) begin
                    stage_detect[s] <= reg_wdata;
                end
                if (wr_gain) begin
                    stage_gain[s] <= reg_wdata;
                end
                if (wr_dly) begin
                    stage_delay[s] <= reg_wdata[7:0];
                end
            end
        end

        // delay line sees a new value only on cancel sync
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                active_delay[s] <= PCSCR_RST_DELAY;
            end else if (cancel_event) begin
                active_delay[s] <= stage_delay[s];
            end
        end

        // cut command carries the gain level as target
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                cancel_out[s] <= '0;
            end else begin
                cancel_out[s].fire      <= over && avail;
                cancel_out[s].target_sq <= (over && avail) ? stage_gain[s] : 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // canceller counts for stages 3 and 4

    for (genvar c = 0; c < PCSCR_COUNTS; c++) begin : g_count
        logic wr_cnt;

        assign wr_cnt      = reg_write && reg_addr == PCSCR_OFS_COUNT[c];
        assign count_rd[c] = {16{reg_addr == PCSCR_OFS_COUNT[c]}} & {12'h000, stage_count[c]};

        // four-bit field, range not clamped: software owns the 0..8 limit
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                stage_count[c] <= PCSCR_RST_COUNT;
            end else if (wr_cnt) begin
                stage_count[c] <= reg_wdata[3:0];
            end
        end

        // allocation swaps only on resource sync, never mid-run
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                active_count[c] <= PCSCR_RST_COUNT;
            end else if (resource_event) begin
                active_count[c] <= stage_count[c];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status and read mux

    logic       alloc_over;
    logic       delay_low;
    logic [2:0] delay_low_vec;

    // only stages 3 and 4 are visible here, so the sum check is partial
    assign alloc_over = ({1'b0, stage_count[0]} + {1'b0, stage_count[1]}) > PCSCR_MAX_CANCELLERS;

    for (genvar d = 0; d < PCSCR_STAGES; d++) begin : g_low
        assign delay_low_vec[d] = active_delay[d] < PCSCR_MIN_DELAY;
    end
    assign delay_low = |delay_low_vec;

    // unmapped and write-only addresses read zero
    always_comb begin
        next_rdata = 16'h0000;
        for (int i = 0; i < PCSCR_STAGES; i++) begin
            next_rdata = next_rdata | stage_rd[i];
        end
        for (int i = 0; i < PCSCR_COUNTS; i++) begin
            next_rdata = next_rdata | count_rd[i];
        end
        if (reg_addr == PCSCR_OFS_CANCEL_SEL) begin
            next_rdata = {13'h0000, cancel_sel};
        end
        if (reg_addr == PCSCR_OFS_RESOURCE_SEL) begin
            next_rdata = {13'h0000, resource_sel};
        end
        if (reg_addr == PCSCR_OFS_STATUS) begin
            next_rdata = {6'h00, delay_low, alloc_over, active_count[1], active_count[0]};
        end
    end

    // data stand exactly one cycle after the read strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_read ? next_rdata : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    chk_detect_readback: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && reg_addr == PCSCR_OFS_DETECT[1] |=> reg_rdata == $past(stage_detect[1]))
        else $error("detect threshold read back wrong");

    chk_reset_clear: assert property (@(posedge clock)
        !rst_n |=> stage_gain[2] == 16'h0000 && stage_delay[0] == 8'h00 && stage_count[1] == 4'h0)
        else $error("register not cleared by reset");

    chk_thresh_full: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && reg_addr == PCSCR_OFS_GAIN[0] |=> stage_gain[0] == $past(reg_wdata)
        ##1 (reg_read && reg_addr == PCSCR_OFS_GAIN[0]) [*1] |=> reg_rdata == stage_gain[0])
        else $error("gain threshold not stored at full width");

    chk_delay_width: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && reg_addr == PCSCR_OFS_DELAY[2] |=> reg_rdata[15:8] == 8'h00
        && reg_rdata[7:0] == $past(stage_delay[2]))
        else $error("delay reserved bits not zero");

    chk_delay_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !cancel_event |=> active_delay[1] == $past(active_delay[1]))
        else $error("active delay moved without cancel sync");

    chk_delay_load: assert property (@(posedge clock) disable iff (!rst_n)
        cancel_event |=> active_delay[0] == $past(stage_delay[0]))
        else $error("active delay not loaded on cancel sync");

    chk_count_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !resource_event ##1 !resource_event |-> $stable(active_count[0]) && $stable(active_count[1]))
        else $error("allocation changed without resource sync");

    chk_count_load: assert property (@(posedge clock) disable iff (!rst_n)
        resource_event |=> active_count[1] == $past(stage_count[1]))
        else $error("allocation not loaded on resource sync");

    chk_peak_cut: assert property (@(posedge clock) disable iff (!rst_n)
        peak_in[2].valid && peak_in[2].mag_sq > stage_detect[2] && canceller_free[2]
        && active_count[1] != 4'h0 |=> cancel_out[2].fire && cancel_out[2].target_sq == $past(stage_gain[2]))
        else $error("over-threshold peak not cut to gain level");

    chk_peak_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        !peak_in[0].valid || peak_in[0].mag_sq <= stage_detect[0] |=> !cancel_out[0].fire)
        else $error("cut issued without over-threshold peak");

    chk_sel_never: assert property (@(posedge clock) disable iff (!rst_n)
        cancel_sel == PCSCR_SRC_NEVER [*2] |-> !cancel_event)
        else $error("cancel sync fired with source never");

    chk_sel_always: assert property (@(posedge clock) disable iff (!rst_n)
        resource_sel == PCSCR_SRC_ALWAYS |=> resource_event)
        else $error("resource sync idle with source always");

    chk_software_sync_source: assert property (@(posedge clock) disable iff (!rst_n)
        cancel_sel == PCSCR_SRC_SW && sw_cancel |=> cancel_event ##1 active_delay[2] == $past(stage_delay[2]))
        else $error("software trigger did not load delays");

endmodule

/* File: hw/pcscr_pkg.sv */
// Purpose: constants, types and register map for the peak cancel stage config registers
// Assumes: 8-bit register address, 16-bit register data, one 25 MHz clock
// Notes:   stages are indexed 0..2 for peak cancel stages 2..4
package pcscr_pkg;

    localparam int PCSCR_STAGES = 3;
    localparam int PCSCR_COUNTS = 2;
    localparam int PCSCR_ADDR_W = 8;
    localparam int PCSCR_DATA_W = 16;
    localparam int PCSCR_DELAY_W = 8;
    localparam int PCSCR_COUNT_W = 4;
    localparam int PCSCR_SEL_W = 3;

    // register offsets, per stage and per count, then shared
    localparam logic [7:0] PCSCR_OFS_DETECT [PCSCR_STAGES] = '{8'h39, 8'h41, 8'h49};
    localparam logic [7:0] PCSCR_OFS_GAIN   [PCSCR_STAGES] = '{8'h3a, 8'h42, 8'h4a};
    localparam logic [7:0] PCSCR_OFS_DELAY  [PCSCR_STAGES] = '{8'h3b, 8'h43, 8'h4b};
    localparam logic [7:0] PCSCR_OFS_COUNT  [PCSCR_COUNTS] = '{8'h40, 8'h48};
    localparam logic [7:0] PCSCR_OFS_CANCEL_SEL   = 8'h4c;
    localparam logic [7:0] PCSCR_OFS_RESOURCE_SEL = 8'h4d;
    localparam logic [7:0] PCSCR_OFS_SOFTWARE_SYNC_SOURCE   = 8'h4e;
    localparam logic [7:0] PCSCR_OFS_STATUS       = 8'h4f;

    // field positions
    localparam int PCSCR_SW_CANCEL_BIT   = 0;
    localparam int PCSCR_SW_RESOURCE_BIT = 1;
    localparam int PCSCR_ST_OVER_BIT     = 8;
    localparam int PCSCR_ST_LOWDLY_BIT   = 9;

    // reset values
    localparam logic [15:0] PCSCR_RST_THRESH = 16'h0000;
    localparam logic [7:0]  PCSCR_RST_DELAY  = 8'h00;
    localparam logic [3:0]  PCSCR_RST_COUNT  = 4'h0;
    localparam logic [2:0]  PCSCR_RST_SEL    = 3'h0;

    // legal limits
    localparam logic [4:0] PCSCR_MAX_CANCELLERS = 5'h08;
    localparam logic [7:0] PCSCR_MIN_DELAY      = 8'h05;

    typedef enum logic [2:0] {
        PCSCR_SRC_NEVER  = 3'b000,
        PCSCR_SRC_SW     = 3'b001,
        PCSCR_SRC_TIMER  = 3'b010,
        PCSCR_SRC_SYNC_A = 3'b011,
        PCSCR_SRC_SYNC_B = 3'b100,
        PCSCR_SRC_ALWAYS = 3'b101
    } pcscr_sync_src_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] mag_sq;
    } pcscr_peak_t;

    typedef struct packed {
        logic        fire;
        logic [15:0] target_sq;
    } pcscr_cancel_t;

endpackage

/* File: hw/pcscr_sync_sel.sv */
// Purpose: pick one sync source by a three-bit code and issue a one-cycle event
// Assumes: all event inputs are one-cycle pulses on clock
// Notes:   codes 6 and 7 produce no event
`timescale 1ns/1ps
module pcscr_sync_sel (
    input  wire logic                            clock,
    input  wire logic                            rst_n,
    input  wire logic [pcscr_pkg::PCSCR_SEL_W-1:0] select,
    input  wire logic                            sw_event,
    input  wire logic                            timer_event,
    input  wire logic                            sync_a_event,
    input  wire logic                            sync_b_event,
    output logic                                 event_pulse
);
    import pcscr_pkg::*;

    logic next_event;

    // source decode; invalid codes fall through to no event
    assign next_event = (select == PCSCR_SRC_SW     && sw_event)
                      | (select == PCSCR_SRC_TIMER  && timer_event)
                      | (select == PCSCR_SRC_SYNC_A && sync_a_event)
                      | (select == PCSCR_SRC_SYNC_B && sync_b_event)
                      | (select == PCSCR_SRC_ALWAYS);

    // registered so the event leaves as a clean flop output
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            event_pulse <= 1'b0;
        end else begin
            event_pulse <= next_event;
        end
    end

endmodule

/* File: tb/pcscr_regs_tb.sv */
// Purpose: self-checking bench for the peak cancel stage config registers
// Assumes: plain strobe register port, sync pins pulsed for three cycles
// Notes:   a behavioural model of stored and active values predicts every result
`timescale 1ns/1ps
module pcscr_regs_tb;
    import pcscr_pkg::*;

    logic                    clock = 1'b0;
    logic                    rst_n = 1'b0;
    logic [PCSCR_ADDR_W-1:0] reg_addr = '0;
    logic [PCSCR_DATA_W-1:0] reg_wdata = '0;
    logic                    reg_write = 1'b0;
    logic                    reg_read = 1'b0;
    logic [PCSCR_DATA_W-1:0] reg_rdata;
    logic                    timer_pin = 1'b0;
    logic                    sync_a_pin = 1'b0;
    logic                    sync_b_pin = 1'b0;
    pcscr_peak_t             peak_in [PCSCR_STAGES];
    logic [PCSCR_STAGES-1:0] canceller_free = '1;
    pcscr_cancel_t           cancel_out [PCSCR_STAGES];
    logic [PCSCR_DELAY_W-1:0] active_delay [PCSCR_STAGES];
    logic [PCSCR_COUNT_W-1:0] active_count [PCSCR_COUNTS];
    int                      mismatches = 0;
    int                      n_tests = 0;
    int                      seed = 32'hf0a837a9;
    int                      mdl [int];
    logic [7:0]              act_dly [PCSCR_STAGES];
    logic [3:0]              act_cnt [PCSCR_COUNTS];
    logic [7:0]              regs_l [13] = '{8'h39, 8'h3a, 8'h3b, 8'h40, 8'h41, 8'h42, 8'h43,
                                             8'h48, 8'h49, 8'h4a, 8'h4b, 8'h3c, 8'h4e};

    pcscr_regs u_pcscr_regs (
        .clock          (clock),
        .rst_n          (rst_n),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_write      (reg_write),
        .reg_read       (reg_read),
        .reg_rdata      (reg_rdata),
        .timer_pin      (timer_pin),
        .sync_a_pin     (sync_a_pin),
        .sync_b_pin     (sync_b_pin),
        .peak_in        (peak_in),
        .canceller_free (canceller_free),
        .cancel_out     (cancel_out),
        .active_delay   (active_delay),
        .active_count   (active_count)
    );

    // 25 MHz clock
    always #20 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    // model helpers
    function automatic logic [15:0] mask_of(input logic [7:0] a);
        if (a inside {PCSCR_OFS_DETECT, PCSCR_OFS_GAIN}) return 16'hffff;
        if (a inside {PCSCR_OFS_DELAY}) return 16'h00ff;
        if (a inside {PCSCR_OFS_COUNT}) return 16'h000f;
        if (a inside {PCSCR_OFS_CANCEL_SEL, PCSCR_OFS_RESOURCE_SEL}) return 16'h0007;
        return 16'h0000; // unmapped, trigger and status hold nothing writable
    endfunction

    function automatic logic [15:0] mexp(input logic [7:0] a);
        return mdl.exists(a) ? 16'(mdl[a]) : 16'h0000;
    endfunction

    function automatic logic [15:0] stat_exp();
        logic low;
        low = 1'b0;
        foreach (act_dly[s]) low = low | (act_dly[s] < 8'd5);
        return {6'h00, low, (mexp(8'h40) + mexp(8'h48)) > 16'd8, act_cnt[1], act_cnt[0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // bus and pin drivers; strobes last one cycle, a gap cycle follows each
    task automatic bus(input logic [7:0] a, input logic [15:0] d, input logic is_wr);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= is_wr;
        reg_read <= !is_wr;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(a, d, 1'b1);
        if (mask_of(a) != 16'h0000) mdl[a] = int'(d & mask_of(a));
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        bus(a, 16'h0000, 1'b0);
        check(reg_rdata, exp);
    endtask

    task automatic settle();
        repeat (8) @(posedge clock);
        #1;
    endtask

    task automatic chk_active();
        foreach (act_dly[s]) check({8'h00, active_delay[s]}, {8'h00, act_dly[s]});
        foreach (act_cnt[c]) check({12'h000, active_count[c]}, {12'h000, act_cnt[c]});
    endtask

    // model of a sync event in both domains: active copies take the stored values
    task automatic load_act();
        foreach (act_dly[i]) act_dly[i] = 8'(mdl[PCSCR_OFS_DELAY[i]]);
        foreach (act_cnt[i]) act_cnt[i] = 4'(mdl[PCSCR_OFS_COUNT[i]]);
    endtask

    // pins held three cycles so the input synchroniser cannot miss the edge
    task automatic fire(input int k);
        if (k == 1) begin
            wr(PCSCR_OFS_SOFTWARE_SYNC_SOURCE, 16'h0003);
        end else begin
            @(posedge clock);
            timer_pin <= (k == 2);
            sync_a_pin <= (k == 3);
            sync_b_pin <= (k == 4);
            repeat (3) @(posedge clock);
            timer_pin <= 1'b0;
            sync_a_pin <= 1'b0;
            sync_b_pin <= 1'b0;
        end
    endtask

    task automatic do_reset(input int cycles);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (cycles) @(posedge clock);
        rst_n <= 1'b1;
        mdl.delete();
        foreach (act_dly[s]) act_dly[s] = 8'h00;
        foreach (act_cnt[c]) act_cnt[c] = 4'h0;
        @(posedge clock);
        #1;
        chk_active();
        foreach (regs_l[i]) rd_chk(regs_l[i], 16'h0000);
        rd_chk(PCSCR_OFS_STATUS, stat_exp());
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [15:0] det;
        logic [15:0] mag;
        logic [2:0]  fr;
        logic        exp_fire;
        int          s;
        foreach (peak_in[i]) peak_in[i] = '0;
        do_reset(12);
        // random writes, back-to-back readback; active copies must not move
        foreach (regs_l[i]) wr(regs_l[i], 16'($random(seed)));
        wr(PCSCR_OFS_STATUS, 16'hffff);
        foreach (regs_l[i]) rd_chk(regs_l[i], mexp(regs_l[i]));
        rd_chk(PCSCR_OFS_STATUS, stat_exp());
        chk_active();
        // every selector code in both sync domains against every source, one at a time
        for (int c = 0; c < 8; c++) begin
            wr(PCSCR_OFS_CANCEL_SEL, 16'h0000);
            wr(PCSCR_OFS_RESOURCE_SEL, 16'h0000);
            settle();
            // real pulses up to 498 long, delay (length-1)/2 stays inside 5..255
            foreach (act_dly[i]) wr(PCSCR_OFS_DELAY[i], 16'((($random(seed) & 32'h1e7) + 10) / 2));
            foreach (act_cnt[i]) wr(PCSCR_OFS_COUNT[i], 16'($random(seed) & 32'h3));
            wr(PCSCR_OFS_CANCEL_SEL, 16'(c));
            wr(PCSCR_OFS_RESOURCE_SEL, 16'(c));
            rd_chk(PCSCR_OFS_CANCEL_SEL, 16'(c));
            rd_chk(PCSCR_OFS_RESOURCE_SEL, 16'(c));
            settle();
            if (c == 5) load_act();
            chk_active();
            for (int k = 1; k < 5; k++) begin
                fire(k);
                settle();
                if (k == c) load_act();
                chk_active();
            end
        end
        // allocations then peaks near each threshold, zero counts included
        wr(PCSCR_OFS_RESOURCE_SEL, 16'h0001);
        for (int p = 0; p < 3; p++) begin
            wr(PCSCR_OFS_COUNT[0], 16'(p));
            wr(PCSCR_OFS_COUNT[1], 16'(2 - p));
            chk_active();
            wr(PCSCR_OFS_SOFTWARE_SYNC_SOURCE, 16'h0002);
            settle();
            foreach (act_cnt[i]) act_cnt[i] = 4'(mdl[PCSCR_OFS_COUNT[i]]);
            chk_active();
            rd_chk(PCSCR_OFS_STATUS, stat_exp());
            foreach (act_dly[i]) begin
                wr(PCSCR_OFS_DETECT[i], 16'(($random(seed) & 32'hfff0) + 2));
                wr(PCSCR_OFS_GAIN[i], 16'($random(seed)));
                rd_chk(PCSCR_OFS_GAIN[i], mexp(PCSCR_OFS_GAIN[i]));
            end
            repeat (20) begin
                s = int'($unsigned($random(seed)) % 3);
                det = mexp(PCSCR_OFS_DETECT[s]);
                mag = det + 16'($unsigned($random(seed)) % 3) - 16'h0001;
                fr = 3'($random(seed)) | 3'b010;
                @(posedge clock);
                peak_in[s] <= '{valid: 1'b1, mag_sq: mag};
                canceller_free <= fr;
                @(posedge clock);
                peak_in[s] <= '{valid: 1'b0, mag_sq: mag};
                #1;
                exp_fire = fr[s] && (mag > det) && ((s == 0) ? 1'b1 : (act_cnt[s - 1] != 4'h0));
                check({15'h0000, cancel_out[s].fire}, {15'h0000, exp_fire});
                check(cancel_out[s].target_sq, exp_fire ? mexp(PCSCR_OFS_GAIN[s]) : 16'h0000);
            end
        end
        // second reset in mid-run clears everything again
        do_reset(3);
        finish_test();
    end

    // watchdog: the sequence needs well under 6000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        finish_test();
    end
endmodule
